/* inc/pcf_consts.svh */
`ifndef PCF_CONSTS_SVH
`define PCF_CONSTS_SVH

`define PCF_ADDR_W       12
`define PCF_GRP_LSB      7
`define PCF_GRP_STRIDE   12'h080
`define PCF_OFS_DIR      7'h00
`define PCF_OFS_OUT      7'h10
`define PCF_OFS_IN       7'h20
`define PCF_OFS_MUX      7'h30
`define PCF_OFS_SETUP    7'h40
`define PCF_BIT_STRONG   6
`define PCF_BIT_PULL     2
`define PCF_BIT_IEN      1
`define PCF_BIT_TAKE     0
`define PCF_SETUP_MASK   8'h47
`define PCF_SETUP_RST    8'h00
`define PCF_MUX_RST      8'h00
`define PCF_SEL_EVEN_LSB 0
`define PCF_SEL_ODD_LSB  4
`define PCF_NFUNC        9
`define PCF_SYNC_LAT     3

`endif

/* inc/pcf_pkg.sv */
package pcf_pkg;

	typedef enum logic [3:0] {
		PCF_FUNC_A = 4'h0,
		PCF_FUNC_B = 4'h1,
		PCF_FUNC_C = 4'h2,
		PCF_FUNC_D = 4'h3,
		PCF_FUNC_E = 4'h4,
		PCF_FUNC_F = 4'h5,
		PCF_FUNC_G = 4'h6,
		PCF_FUNC_H = 4'h7,
		PCF_FUNC_I = 4'h8
	} pcf_func_t;

endpackage

/* logic/pcf_pin_cell.sv */
`include "pcf_consts.svh"

module pcf_pin_cell (
	input  wire logic              take,
	input  wire pcf_pkg::pcf_func_t sel,
	input  wire logic              port_dir,
	input  wire logic              port_out,
	input  wire logic [8:0]        periph_oe,
	input  wire logic [8:0]        periph_out,
	output logic                   pad_oe,
	output logic                   pad_out,
	output logic [8:0]             func_hot
);
	import pcf_pkg::*;

	logic [8:0] hot;

	// selector decode; reserved codes pick nothing
	always_comb begin
		hot = 9'h000;
		unique case (sel)
			PCF_FUNC_A: hot = 9'h001;
			PCF_FUNC_B: hot = 9'h002;
			PCF_FUNC_C: hot = 9'h004;
			PCF_FUNC_D: hot = 9'h008;
			PCF_FUNC_E: hot = 9'h010;
			PCF_FUNC_F: hot = 9'h020;
			PCF_FUNC_G: hot = 9'h040;
			PCF_FUNC_H: hot = 9'h080;
			PCF_FUNC_I: hot = 9'h100;
			default:    hot = 9'h000;
		endcase
	end

	// port registers or the chosen peripheral own the pad
	always_comb begin
		if (take) begin
			func_hot = hot;
			pad_oe   = |(hot & periph_oe);
			pad_out  = |(hot & periph_out);
		end else begin
			func_hot = 9'h000;
			pad_oe   = port_dir;
			pad_out  = port_out;
		end
	end

endmodule

/* logic/pcf_port_pads.sv */
// Our own choice: strobed register access.
`include "pcf_consts.svh"

module pcf_port_pads #(
	parameter int NGROUPS = 2,
	parameter int NPINS   = 32
) (
	input  wire logic                            clock,
	input  wire logic                            srst,
	input  wire logic [`PCF_ADDR_W-1:0]          addr,
	input  wire logic [7:0]                      wdata,
	input  wire logic                            wr_en,
	input  wire logic                            rd_en,
	output logic [7:0]                           rdata,
	input  wire logic [NGROUPS*NPINS-1:0]        pad_in,
	output logic [NGROUPS*NPINS-1:0]             pad_oe,
	output logic [NGROUPS*NPINS-1:0]             pad_out,
	output logic [NGROUPS*NPINS-1:0]             pad_strong,
	output logic [NGROUPS*NPINS-1:0]             pad_pull_en,
	output logic [NGROUPS*NPINS-1:0]             pad_in_en,
	input  wire logic [NGROUPS*NPINS*9-1:0]      periph_oe,
	input  wire logic [NGROUPS*NPINS*9-1:0]      periph_out,
	output logic [NGROUPS*NPINS*9-1:0]           periph_in
);
	import pcf_pkg::*;

	localparam int T = NGROUPS * NPINS;

	typedef struct packed {
		logic [T-1:0]        dir;
		logic [T-1:0]        out;
		logic [T-1:0][7:0]   setup;
		logic [T/2-1:0][7:0] mux;
		logic [T-1:0]        s1;
		logic [T-1:0]        s2;
		logic [T-1:0]        inr;
		logic [7:0]          rdata;
	} pcf_state_t;

	pcf_state_t q;
	pcf_state_t d;

	logic [`PCF_ADDR_W-`PCF_GRP_LSB-1:0] grp;
	logic [`PCF_GRP_LSB-1:0]             ofs;
	logic [T*9-1:0]                      hot;

	assign grp = addr[`PCF_ADDR_W-1:`PCF_GRP_LSB];
	assign ofs = addr[`PCF_GRP_LSB-1:0];

	always_comb begin
		int g;
		int p;
		logic [7:0] rv;
		g  = 0;
		p  = 0;
		rv = 8'h00;
		d  = q;
		// two-stage synchroniser, then gated by the input buffer enable
		d.s1 = pad_in;
		d.s2 = q.s1;
		for (int i = 0; i < T; i++) begin
			d.inr[i] = q.setup[i][`PCF_BIT_IEN] & q.s2[i];
		end
		for (int i = 0; i < T; i++) begin
			g = i / NPINS;
			p = i % NPINS;
			if (grp == ($bits(grp))'(g)) begin
				if (ofs == 7'(`PCF_OFS_SETUP + p)) begin
					if (wr_en) begin
						d.setup[i] = wdata & `PCF_SETUP_MASK;
					end
					rv = q.setup[i];
				end
				if (ofs == 7'(`PCF_OFS_DIR + p / 8)) begin
					if (wr_en) begin
						d.dir[i] = wdata[p % 8];
					end
					rv[p % 8] = q.dir[i];
				end
				if (ofs == 7'(`PCF_OFS_OUT + p / 8)) begin
					if (wr_en) begin
						d.out[i] = wdata[p % 8];
					end
					rv[p % 8] = q.out[i];
				end
				if (ofs == 7'(`PCF_OFS_IN + p / 8)) begin
					rv[p % 8] = q.inr[i];
				end
				if ((p % 2 == 0) && ofs == 7'(`PCF_OFS_MUX + p / 2)) begin
					if (wr_en) begin
						d.mux[i / 2] = wdata;
					end
					rv = q.mux[i / 2];
				end
			end
		end
		d.rdata = rd_en ? rv : 8'h00;
		if (srst) begin
			d.dir   = '0;
			d.out   = '0;
			d.s1    = '0;
			d.s2    = '0;
			d.inr   = '0;
			d.rdata = 8'h00;
			for (int i = 0; i < T; i++) begin
				d.setup[i] = `PCF_SETUP_RST;
			end
			for (int m = 0; m < T / 2; m++) begin
				d.mux[m] = `PCF_MUX_RST;
			end
		end
	end

	always_ff @(posedge clock) begin
		q <= d;
	end

	assign rdata = q.rdata;

	for (genvar i = 0; i < T; i++) begin : g_pin
		pcf_func_t sel;

		// even pins take the low nibble, odd pins the high nibble
		if (i % 2 == 0) begin : g_even
			assign sel = pcf_func_t'(q.mux[i / 2][`PCF_SEL_EVEN_LSB +: 4]);
		end else begin : g_odd
			assign sel = pcf_func_t'(q.mux[i / 2][`PCF_SEL_ODD_LSB +: 4]);
		end

		pcf_pin_cell u_cell (
			.take       (q.setup[i][`PCF_BIT_TAKE]),
			.sel        (sel),
			.port_dir   (q.dir[i]),
			.port_out   (q.out[i]),
			.periph_oe  (periph_oe[i*9 +: 9]),
			.periph_out (periph_out[i*9 +: 9]),
			.pad_oe     (pad_oe[i]),
			.pad_out    (pad_out[i]),
			.func_hot   (hot[i*9 +: 9])
		);

		assign pad_strong[i]  = q.setup[i][`PCF_BIT_STRONG];
		assign pad_pull_en[i] = q.setup[i][`PCF_BIT_PULL];
		assign pad_in_en[i]   = q.setup[i][`PCF_BIT_IEN];
		assign periph_in[i*9 +: 9] = hot[i*9 +: 9] & {9{q.inr[i]}};

		property p_reserved;
			@(posedge clock) disable iff (srst)
			(q.setup[i][`PCF_BIT_TAKE] && sel > PCF_FUNC_I)
				|-> (!pad_oe[i] && hot[i*9 +: 9] == 9'h000);
		endproperty
		a_reserved: assert property (p_reserved)
			else $error("reserved selector still routes a function");

		property p_func_a;
			@(posedge clock) disable iff (srst)
			(q.setup[i][`PCF_BIT_TAKE] && sel == PCF_FUNC_A)
				|-> (pad_oe[i] == periph_oe[i*9]
				&& pad_out[i] == periph_out[i*9]);
		endproperty
		a_func_a: assert property (p_func_a)
			else $error("code zero does not route function A");

		property p_port_owns;
			@(posedge clock) disable iff (srst)
			!q.setup[i][`PCF_BIT_TAKE]
				|-> (pad_oe[i] == q.dir[i] && pad_out[i] == q.out[i]
				&& hot[i*9 +: 9] == 9'h000);
		endproperty
		a_port_owns: assert property (p_port_owns)
			else $error("port registers do not own the pad");

		property p_periph_owns;
			@(posedge clock) disable iff (srst)
			(q.setup[i][`PCF_BIT_TAKE] && sel <= PCF_FUNC_I)
				|-> (pad_oe[i] == periph_oe[i*9 + 32'(sel)]
				&& pad_out[i] == periph_out[i*9 + 32'(sel)]);
		endproperty
		a_periph_owns: assert property (p_periph_owns)
			else $error("selected peripheral does not own the pad");

		property p_in_off;
			@(posedge clock) disable iff (srst)
			!q.setup[i][`PCF_BIT_IEN] |=> !q.inr[i];
		endproperty
		a_in_off: assert property (p_in_off)
			else $error("pin sampled with input buffer off");

		property p_in_on;
			@(posedge clock) disable iff (srst)
			(q.setup[i][`PCF_BIT_IEN] && !$past(srst, 3)
				&& !$past(srst, 2) && !$past(srst, 1))
				|=> (q.inr[i] == $past(pad_in[i], 3));
		endproperty
		a_in_on: assert property (p_in_on)
			else $error("pin not sampled with input buffer on");

		property p_unused_zero;
			@(posedge clock) disable iff (srst)
			(q.setup[i] & ~`PCF_SETUP_MASK) == 8'h00;
		endproperty
		a_unused_zero: assert property (p_unused_zero)
			else $error("unused setup bits hold a one");

		property p_strong;
			@(posedge clock) disable iff (srst)
			(wr_en && grp == ($bits(grp))'(i / NPINS)
				&& ofs == 7'(`PCF_OFS_SETUP + i % NPINS))
				|=> (pad_strong[i] == $past(wdata[`PCF_BIT_STRONG])
				&& pad_pull_en[i] == $past(wdata[`PCF_BIT_PULL]));
		endproperty
		a_strong: assert property (p_strong)
			else $error("drive or pull does not follow setup write");

		property p_setup_store;
			@(posedge clock) disable iff (srst)
			(wr_en && grp == ($bits(grp))'(i / NPINS)
				&& ofs == 7'(`PCF_OFS_SETUP + i % NPINS))
				|=> (pad_in_en[i] == $past(wdata[`PCF_BIT_IEN])
				&& q.setup[i] == ($past(wdata) & `PCF_SETUP_MASK));
		endproperty
		a_setup_store: assert property (p_setup_store)
			else $error("setup write not stored for its line");

		property p_periph_in;
			@(posedge clock) disable iff (srst)
			(q.setup[i][`PCF_BIT_TAKE] && sel <= PCF_FUNC_I)
				|-> (periph_in[i*9 + 32'(sel)] == q.inr[i]
				&& $countones(periph_in[i*9 +: 9]) <= 1);
		endproperty
		a_periph_in: assert property (p_periph_in)
			else $error("pin level not passed to chosen function");

		property p_periph_in_off;
			@(posedge clock) disable iff (srst)
			!q.setup[i][`PCF_BIT_TAKE] |-> periph_in[i*9 +: 9] == 9'h000;
		endproperty
		a_periph_in_off: assert property (p_periph_in_off)
			else $error("function sees pin without takeover");
	end

	property p_readback;
		@(posedge clock) disable iff (srst)
		(rd_en && addr == 12'h040)
			|=> (rdata == $past(q.setup[0]));
	endproperty
	a_readback: assert property (p_readback)
		else $error("setup byte of line 0 not read back");

	property p_rdata_idle;
		@(posedge clock) disable iff (srst)
		!rd_en |=> rdata == 8'h00;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data not zero without a read");

	property p_dir_write;
		@(posedge clock) disable iff (srst)
		(wr_en && addr == 12'h000) |=> q.dir[7:0] == $past(wdata);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("direction byte not stored");

	property p_in_read;
		@(posedge clock) disable iff (srst)
		(rd_en && addr == 12'h020) |=> rdata == $past(q.inr[7:0]);
	endproperty
	a_in_read: assert property (p_in_read)
		else $error("input byte not read back");

	property p_mux_write;
		@(posedge clock) disable iff (srst)
		(wr_en && addr == 12'h030) |=> q.mux[0] == $past(wdata);
	endproperty
	a_mux_write: assert property (p_mux_write)
		else $error("selector byte not stored");

	if (NGROUPS > 1) begin : g_stride
		property p_stride;
			@(posedge clock) disable iff (srst)
			(wr_en && addr == (`PCF_GRP_STRIDE + 12'h040))
				|=> (q.setup[NPINS] == ($past(wdata) & `PCF_SETUP_MASK)
				&& $stable(q.setup[0]));
		endproperty
		a_stride: assert property (p_stride)
			else $error("second group setup not at stride");
	end

	property p_reset;
		@(posedge clock)
		srst |=> (q.setup == '0 && q.mux == '0 && rdata == 8'h00);
	endproperty
	a_reset: assert property (p_reset)
		else $error("setup not cleared by reset");

endmodule

/* bench/pcf_pad_model.sv */
module pcf_pad_model #(
	parameter int T = 64
) (
	input  wire logic         clock,
	input  wire logic [T-1:0] pad_oe,
	input  wire logic [T-1:0] pad_out,
	input  wire logic [T-1:0] pad_pull_en,
	input  wire logic [8:0]   fpat,
	output logic [T-1:0]      pad_in,
	output logic [T*9-1:0]    periph_oe,
	output logic [T*9-1:0]    periph_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tog = 1'b0;
	always @(posedge clock) begin
		tog <= ~tog;
	end
	// an undriven pad wobbles unless its pull holds it high
	always_comb begin
		for (int i = 0; i < T; i++) begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : (pad_pull_en[i] | tog);
			periph_oe[i*9 +: 9] = 9'h1ff;
			periph_out[i*9 +: 9] = fpat;
		end
	end
endmodule

/* bench/test_pad_config_and_function_select.sv */
module test_pad_config_and_function_select;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int T = 64;
	logic           clock = 1'b0;
	logic           srst = 1'b1;
	logic           wr_en = 1'b0;
	logic           rd_en = 1'b0;
	logic [11:0]    addr = 12'h000;
	logic [7:0]     wdata = 8'h00;
	logic [7:0]     rdata;
	logic [7:0]     d;
	logic [8:0]     fpat = 9'h000;
	logic [T-1:0]   pad_in, pad_oe, pad_out, pad_strong, pad_pull_en, pad_in_en;
	logic [T*9-1:0] periph_oe, periph_out, periph_in;
	int             fails = 0;
	int             n_tests = 0;
	int             cyc = 0;

	always #4 clock = ~clock;

	pcf_port_pads DUT (.clock(clock), .srst(srst), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.pad_in(pad_in), .pad_oe(pad_oe), .pad_out(pad_out),
		.pad_strong(pad_strong), .pad_pull_en(pad_pull_en),
		.pad_in_en(pad_in_en), .periph_oe(periph_oe),
		.periph_out(periph_out), .periph_in(periph_in));

	pcf_pad_model #(.T(T)) pads (.clock(clock), .pad_oe(pad_oe),
		.pad_out(pad_out), .pad_pull_en(pad_pull_en), .fpat(fpat),
		.pad_in(pad_in), .periph_oe(periph_oe), .periph_out(periph_out));

	task automatic wr(input logic [11:0] a, input logic [7:0] v);
		@(posedge clock);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		@(negedge clock);
	endtask

	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		@(negedge clock);
		d = rdata;
	endtask

	task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: reg %h want %h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: bit %b want %b", $time, g, e);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fails++;
			tally_and_finish;
		end
	end

	initial begin
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(12'h040);
		chk_reg(d, 8'h00);
		wr(12'h040, 8'hff);
		rd(12'h040);
		chk_reg(d, 8'h47);
		chk_bit(pad_strong[0], 1'b1);
		chk_bit(pad_pull_en[0], 1'b1);
		chk_bit(pad_in_en[0], 1'b1);
		wr(12'h0c5, 8'h40);
		chk_bit(pad_strong[37], 1'b1);
		chk_bit(pad_strong[5], 1'b0);
		wr(12'h0c0, 8'h04);
		chk_bit(pad_pull_en[32], 1'b1);
		chk_bit(pad_in_en[0], 1'b1);
		rd(12'h045);
		chk_reg(d, 8'h00);
		$display("test setup done");
		// port registers own pin 1 although its selector names a function
		wr(12'h030, 8'h30);
		wr(12'h041, 8'h02);
		wr(12'h000, 8'h02);
		wr(12'h010, 8'h02);
		chk_bit(pad_oe[1], 1'b1);
		chk_bit(pad_out[1], 1'b1);
		repeat (4) @(posedge clock);
		rd(12'h020);
		chk_bit(d[1], 1'b1);
		wr(12'h041, 8'h00);
		rd(12'h020);
		chk_bit(d[1], 1'b0);
		$display("test port done");
		// pins 2 and 3 handed over; even and odd codes differ
		wr(12'h042, 8'h03);
		wr(12'h043, 8'h01);
		for (int c = 0; c < 16; c++) begin
			@(posedge clock);
			fpat <= (c < 9) ? (9'h001 << c) : 9'h000;
			wr(12'h031, {4'(15 - c), 4'(c)});
			chk_bit(pad_oe[2], c < 9);
			chk_bit(pad_out[2], c < 9);
			chk_bit(pad_oe[3], c > 6);
			chk_bit(pad_out[3], 1'b0);
		end
		@(posedge clock);
		fpat <= 9'h001;
		wr(12'h031, 8'h00);
		repeat (4) @(posedge clock);
		rd(12'h020);
		chk_bit(d[2], 1'b1);
		chk_bit(periph_in[18], 1'b1);
		$display("test mux done");
		// reset in mid-run clears setup and selectors
		@(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		rd(12'h042);
		chk_reg(d, 8'h00);
		chk_bit(pad_oe[2], 1'b0);
		chk_bit(periph_in[18], 1'b0);
		$display("test reset done");
		tally_and_finish;
	end
endmodule
